/* File: verilog/dvcr_pkg.sv */
package dvcr_pkg;

	// Timebase and step intervals
	localparam int CLK_NS     = 50;
	localparam int STEP10_NS  = 3000;
	localparam int STEP25_NS  = 6000;
	localparam int SOFT_NS    = 200000;
	localparam int STEP10_CYC = (STEP10_NS + CLK_NS - 1) / CLK_NS;
	localparam int STEP25_CYC = (STEP25_NS + CLK_NS - 1) / CLK_NS;
	localparam int SOFT_CYC   = (SOFT_NS + CLK_NS - 1) / CLK_NS;
	localparam int TW         = 12;
	localparam logic [TW-1:0] STEP10_LIM = TW'(STEP10_CYC);
	localparam logic [TW-1:0] STEP25_LIM = TW'(STEP25_CYC);
	localparam logic [TW-1:0] SOFT_LIM   = TW'(SOFT_CYC);
	// Cycles before the comparators reflect a new working code
	localparam logic [2:0] CMP_LAG = 3'h4;

	// Voltage codes
	localparam int CW = 7;
	localparam logic [CW-1:0] CODE_OFF  = 7'h00;
	localparam logic [CW-1:0] CODE_MIN  = 7'h01;
	localparam logic [CW-1:0] HALF_25MV = 7'h04;
	localparam logic [CW-1:0] HALF_10MV = 7'h0a;
	localparam logic [CW-1:0] CTL_FLOOR = 7'h18;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_IRQ  = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0c;

	// Control register fields (code in [6:0])
	localparam int B_DECAY = 7;
	localparam int B_FINE  = 8;
	localparam int B_CTLR  = 9;
	localparam int B_PWM   = 10;

	// Status register fields (working code in [6:0])
	localparam int S_RAMP = 8;
	localparam int S_MASK = 9;
	localparam int S_STOP = 10;
	localparam int S_PWM  = 11;
	localparam int S_SOFT = 12;

	// Event bits
	localparam int IRQ_RAMP  = 0;
	localparam int IRQ_SOFT  = 1;
	localparam int IRQ_DECAY = 2;
	localparam int IRQ_OFF   = 3;
	localparam int NIRQ      = 4;

	typedef enum {ST_IDLE, ST_RAMP, ST_SOFT, ST_DECAY, ST_OFF} dvcr_state_e;

endpackage

/* File: verilog/dvcr_tmr_if.sv */
`timescale 1ns/1ps
interface dvcr_tmr_if #(parameter int W = 12);
	logic         run;
	logic [W-1:0] limit;
	logic         tick;
	modport ctl (output run, output limit, input tick);
	modport tmr (input run, input limit, output tick);
endinterface

/* File: verilog/dvcr_step_timer.sv */
`timescale 1ns/1ps
module dvcr_step_timer #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control side
	dvcr_tmr_if.tmr  t
);
	logic [W-1:0] cntQ;
	logic         atEnd;

	if (W < 2) begin : g_bad_width
		$error("dvcr_step_timer: width too small");
	end

	// Tick is combinational so one interval is exactly limit cycles long;
	// at or past the end, so a shorter limit mid-count never wraps the counter
	assign atEnd  = t.run && (cntQ >= t.limit - W'(1));
	assign t.tick = atEnd;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cntQ <= '0;
		end else if (!t.run || atEnd) begin
			cntQ <= '0;
		end else begin
			cntQ <= cntQ + W'(1);
		end
	end
endmodule // dvcr_step_timer

/* File: verilog/dvcr_sync.sv */
`timescale 1ns/1ps
module dvcr_sync #(
	parameter int N = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Levels
	input  wire logic [N-1:0] d,
	output logic      [N-1:0] q
);
	if (N < 1) begin : g_bad_n
		$error("dvcr_sync: N must be positive");
	end

	for (genvar i = 0; i < N; i++) begin : g_bit
		logic metaQ;
		logic syncQ;
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				metaQ <= 1'b0;
				syncQ <= 1'b0;
			end else begin
				metaQ <= d[i];
				syncQ <= metaQ;
			end
		end
		assign q[i] = syncQ;
	end
endmodule // dvcr_sync

/* File: verilog/dvcr_ramp.sv */
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Contract
// - Hold 7-bit code, 25 mV per step
// - Controller codes up to 0011000 give 1.000 V
// - Fine range steps every 3 us
// - Coarse range steps every 6 us to target
// - Force fixed-frequency mode during ramp unless decay
// - Mask rail OK while ramping
// - Zero target: ramp to 0.5 V, stop switching
// - Restart from below 0.5 V via soft-start
// - Soft-start lasts fixed 200 us
// - No forced mode after soft-start ramp
// - Decay bit: lower targets decay, not ramp
// - Decay stops both switches, no slew control
// - Decay keeps mask until below overvoltage level
// - Raise during decay waits, then follows ramp
// - Forced fixed-frequency or power-save pulse mode
module dvcr_ramp (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq,
	// Analog comparators (asynchronous)
	input  wire logic        outBelowHalf,
	input  wire logic        outAboveCode,
	input  wire logic        outBelowOv,
	// Switching stage
	output logic [6:0]       workCode,
	output logic [6:0]       refCode,
	output logic             forcePwm,
	output logic             stopSwitch,
	output logic             softStart,
	output logic             railOkMask
);
	localparam int CW = dvcr_pkg::CW;
	localparam int LIM10 = dvcr_pkg::STEP10_CYC - 1;
	localparam int LIM25 = dvcr_pkg::STEP25_CYC - 1;
	localparam int LIMSS = dvcr_pkg::SOFT_CYC - 1;

	dvcr_pkg::dvcr_state_e stateQ, stateD;
	logic [CW-1:0]             targetQ, workQ, workD, halfCode, goal;
	logic                      decayBitQ, fineQ, ctlrQ, pwmBitQ;
	logic                      catchQ, catchD, noForceQ, noForceD;
	logic [dvcr_pkg::NIRQ-1:0] irqStatQ, irqMaskQ, events;
	logic [2:0]                anaSync;
	logic                      belowHalf, aboveCode, belowOv;
	logic [31:0]               ctrlWord, statWord, rdWord;
	logic                      wrEn, rdEn, hitCtrl, hitStat, hitIrq, hitMask, hitAny;
	logic                      stepUp, stepDown, lowerDecay;
	logic                      stopD, pwmD, maskD;
	logic [CW-1:0]             refD;
	logic [2:0]                settleQ;
	logic                      settled, ovClear;

	dvcr_tmr_if #(.W(dvcr_pkg::TW)) tmr ();

	dvcr_sync #(.N(3)) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    ({outBelowOv, outAboveCode, outBelowHalf}),
		.q    (anaSync)
	);
	assign belowHalf = anaSync[0];
	assign aboveCode = anaSync[1];
	assign belowOv   = anaSync[2];

	dvcr_step_timer #(.W(dvcr_pkg::TW)) u_timer (
		.clk  (clk),
		.nrst (nrst),
		.t    (tmr)
	);

	// APB decode; one wait state so data and error come from flops
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	assign hitCtrl = hit(paddr, dvcr_pkg::OFF_CTRL);
	assign hitStat = hit(paddr, dvcr_pkg::OFF_STAT);
	assign hitIrq  = hit(paddr, dvcr_pkg::OFF_IRQ);
	assign hitMask = hit(paddr, dvcr_pkg::OFF_MASK);
	assign hitAny  = hitCtrl | hitStat | hitIrq | hitMask;
	assign wrEn    = psel & penable & pready & pwrite & hitAny;
	assign rdEn    = psel & penable & !pready;

	assign ctrlWord = {21'h000000, pwmBitQ, ctlrQ, fineQ, decayBitQ, targetQ};
	assign statWord = {19'h00000, softStart, forcePwm, stopSwitch, railOkMask,
		(stateQ == dvcr_pkg::ST_RAMP), 1'b0, workQ};
	assign rdWord = hitCtrl ? ctrlWord :
		hitStat ? statWord :
		hitIrq  ? {28'h0000000, irqStatQ} :
		hitMask ? {28'h0000000, irqMaskQ} : 32'h00000000;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= rdEn;
			pslverr <= rdEn & !hitAny;
			prdata  <= (rdEn & !pwrite) ? rdWord : 32'h00000000;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			targetQ   <= dvcr_pkg::CODE_OFF;
			decayBitQ <= 1'b0;
			fineQ     <= 1'b0;
			ctlrQ     <= 1'b0;
			pwmBitQ   <= 1'b0;
			irqMaskQ  <= '0;
		end else if (wrEn && hitCtrl) begin
			targetQ   <= pwdata[CW-1:0];
			decayBitQ <= pwdata[dvcr_pkg::B_DECAY];
			fineQ     <= pwdata[dvcr_pkg::B_FINE];
			ctlrQ     <= pwdata[dvcr_pkg::B_CTLR];
			pwmBitQ   <= pwdata[dvcr_pkg::B_PWM];
		end else if (wrEn && hitMask) begin
			irqMaskQ  <= pwdata[dvcr_pkg::NIRQ-1:0];
		end
	end

	// Sticky events: a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqStatQ <= '0;
			irq      <= 1'b0;
		end else begin
			irqStatQ <= (irqStatQ & ~((wrEn && hitIrq) ? pwdata[dvcr_pkg::NIRQ-1:0] : '0))
				| events;
			irq      <= |(irqStatQ & irqMaskQ);
		end
	end

	// Sequencer
	assign halfCode   = fineQ ? dvcr_pkg::HALF_10MV : dvcr_pkg::HALF_25MV;
	assign goal       = (targetQ == dvcr_pkg::CODE_OFF) ? halfCode : targetQ;
	assign stepUp     = tmr.tick && (workQ < goal);
	assign stepDown   = tmr.tick && (workQ > goal);
	assign lowerDecay = decayBitQ && (targetQ != dvcr_pkg::CODE_OFF) && (targetQ < workQ);
	// The over-voltage level still shows the old code until the output flop
	// and the synchroniser catch up, so decay trusts it only after that
	assign settled    = (settleQ == dvcr_pkg::CMP_LAG);
	assign ovClear    = belowOv && settled;

	assign tmr.run   = (stateQ == dvcr_pkg::ST_RAMP) || (stateQ == dvcr_pkg::ST_SOFT);
	assign tmr.limit = (stateQ == dvcr_pkg::ST_SOFT) ? dvcr_pkg::SOFT_LIM :
		fineQ ? dvcr_pkg::STEP10_LIM : dvcr_pkg::STEP25_LIM;

	always_comb begin
		stateD   = stateQ;
		workD    = workQ;
		catchD   = catchQ;
		noForceD = noForceQ;
		events   = '0;
		case (stateQ)
			dvcr_pkg::ST_IDLE: begin
				if (lowerDecay) begin
					stateD = dvcr_pkg::ST_DECAY;
					workD  = targetQ;
				end else if (workQ != goal) begin
					stateD = dvcr_pkg::ST_RAMP;
				end
			end
			dvcr_pkg::ST_RAMP: begin
				if (lowerDecay && !catchQ) begin
					stateD = dvcr_pkg::ST_DECAY;
					workD  = targetQ;
				end else if (workQ == goal) begin
					catchD   = 1'b0;
					noForceD = 1'b0;
					if (targetQ == dvcr_pkg::CODE_OFF) begin
						stateD = dvcr_pkg::ST_OFF;
						workD  = dvcr_pkg::CODE_OFF;
						events[dvcr_pkg::IRQ_OFF] = 1'b1;
					end else begin
						stateD = dvcr_pkg::ST_IDLE;
						events[dvcr_pkg::IRQ_RAMP] = 1'b1;
					end
				end else if (stepUp) begin
					workD = workQ + 7'h01;
				end else if (stepDown) begin
					workD = workQ - 7'h01;
				end
			end
			dvcr_pkg::ST_SOFT: begin
				if (tmr.tick) begin
					stateD   = dvcr_pkg::ST_RAMP;
					noForceD = 1'b1;
					events[dvcr_pkg::IRQ_SOFT] = 1'b1;
				end
			end
			dvcr_pkg::ST_DECAY: begin
				if (targetQ > workQ) begin
					stateD = dvcr_pkg::ST_RAMP;
					catchD = 1'b1;
				end else if (lowerDecay) begin
					workD = targetQ;
				end else if (ovClear) begin
					stateD = dvcr_pkg::ST_IDLE;
					events[dvcr_pkg::IRQ_DECAY] = 1'b1;
				end
			end
			dvcr_pkg::ST_OFF: begin
				// A code of one from the off state leaves the rail off
				if (targetQ > dvcr_pkg::CODE_MIN) begin
					workD  = halfCode;
					stateD = belowHalf ? dvcr_pkg::ST_SOFT : dvcr_pkg::ST_RAMP;
				end
			end
			default: begin
				stateD = dvcr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stateQ   <= dvcr_pkg::ST_OFF;
			workQ    <= dvcr_pkg::CODE_OFF;
			catchQ   <= 1'b0;
			noForceQ <= 1'b0;
		end else begin
			stateQ   <= stateD;
			workQ    <= workD;
			catchQ   <= catchD;
			noForceQ <= noForceD;
		end
	end

	// Restarts whenever decay takes a new code
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			settleQ <= 3'h0;
		end else if (stateQ != dvcr_pkg::ST_DECAY || workD != workQ) begin
			settleQ <= 3'h0;
		end else if (!settled) begin
			settleQ <= settleQ + 3'h1;
		end
	end

	// Outputs to the switching stage, one cycle behind the sequencer state
	assign stopD = (stateQ == dvcr_pkg::ST_DECAY) || (stateQ == dvcr_pkg::ST_OFF)
		|| ((stateQ == dvcr_pkg::ST_RAMP) && catchQ && aboveCode);
	// Software forcing is ignored after soft-start, where it could pull a high output down
	assign pwmD = !stopD && (stateQ != dvcr_pkg::ST_SOFT) && !noForceQ
		&& (pwmBitQ || ((stateQ == dvcr_pkg::ST_RAMP) && !decayBitQ));
	assign maskD = (stateQ == dvcr_pkg::ST_RAMP) || (stateQ == dvcr_pkg::ST_SOFT)
		|| ((stateQ == dvcr_pkg::ST_DECAY) && !ovClear);
	assign refD = (ctlrQ && !fineQ && (workQ != dvcr_pkg::CODE_OFF)
		&& (workQ < dvcr_pkg::CTL_FLOOR)) ? dvcr_pkg::CTL_FLOOR : workQ;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			workCode   <= dvcr_pkg::CODE_OFF;
			refCode    <= dvcr_pkg::CODE_OFF;
			forcePwm   <= 1'b0;
			stopSwitch <= 1'b1;
			softStart  <= 1'b0;
			railOkMask <= 1'b0;
		end else begin
			workCode   <= workQ;
			refCode    <= refD;
			forcePwm   <= pwmD;
			stopSwitch <= stopD;
			softStart  <= (stateQ == dvcr_pkg::ST_SOFT);
			railOkMask <= maskD;
		end
	end

	// Helper counters for the checks below
	logic [15:0] gapCnt, softCnt;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gapCnt  <= 16'h0000;
			softCnt <= 16'h0000;
		end else begin
			gapCnt  <= (stateQ != dvcr_pkg::ST_RAMP || workD != workQ) ? 16'h0000
				: gapCnt + 16'h0001;
			softCnt <= (stateQ != dvcr_pkg::ST_SOFT) ? 16'h0000 : softCnt + 16'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_step_fine: assert property (
		stateQ == dvcr_pkg::ST_RAMP && fineQ && workD != workQ && stateD == stateQ
		|-> int'(gapCnt) == LIM10)
		else $error("fine step interval wrong");
	a_step_coarse: assert property (
		stateQ == dvcr_pkg::ST_RAMP && !fineQ && workD != workQ && stateD == stateQ
		|-> int'(gapCnt) == LIM25)
		else $error("coarse step interval wrong");
	a_step_size: assert property (
		stateQ == dvcr_pkg::ST_RAMP && stateD == dvcr_pkg::ST_RAMP && workD != workQ
		|-> (workD == workQ + 7'h01) || (workD == workQ - 7'h01))
		else $error("working code jumped");
	a_ramp_pwm: assert property (
		stateQ == dvcr_pkg::ST_RAMP && !decayBitQ && !noForceQ && !catchQ |=> forcePwm)
		else $error("ramp not in forced mode");
	a_ramp_mask: assert property (
		stateQ == dvcr_pkg::ST_RAMP |=> railOkMask)
		else $error("rail ok not masked in ramp");
	a_off_stop: assert property (
		stateQ == dvcr_pkg::ST_RAMP && targetQ == dvcr_pkg::CODE_OFF && workQ == halfCode
		|=> stateQ == dvcr_pkg::ST_OFF ##1 stopSwitch && workCode == dvcr_pkg::CODE_OFF)
		else $error("zero target did not stop");
	a_soft_time: assert property (
		stateQ == dvcr_pkg::ST_SOFT && stateD != dvcr_pkg::ST_SOFT |-> int'(softCnt) == LIMSS)
		else $error("soft-start length wrong");
	a_soft_nopwm: assert property (
		stateQ == dvcr_pkg::ST_RAMP && noForceQ |=> !forcePwm)
		else $error("forced mode after soft-start");
	a_decay_stop: assert property (
		stateQ == dvcr_pkg::ST_DECAY |=> stopSwitch && !forcePwm)
		else $error("switching during decay");
	a_decay_mask: assert property (
		stateQ == dvcr_pkg::ST_DECAY && !belowOv |=> railOkMask)
		else $error("mask released early in decay");
	a_decay_hold: assert property (
		stateQ == dvcr_pkg::ST_DECAY && !settled |=> railOkMask && stopSwitch)
		else $error("decay left before comparators settled");
	a_ctl_map: assert property (
		ctlrQ && !fineQ && workQ != dvcr_pkg::CODE_OFF && workQ < dvcr_pkg::CTL_FLOOR
		|=> refCode == dvcr_pkg::CTL_FLOOR)
		else $error("controller floor mapping wrong");
	a_done_idle: assert property (
		stateQ == dvcr_pkg::ST_RAMP && workQ == goal && targetQ != dvcr_pkg::CODE_OFF
		&& !lowerDecay |=> stateQ == dvcr_pkg::ST_IDLE ##1 !railOkMask)
		else $error("ramp did not end at target");

	c_soft: cover property (stateQ == dvcr_pkg::ST_SOFT ##1 stateQ == dvcr_pkg::ST_RAMP);
	c_decay: cover property (stateQ == dvcr_pkg::ST_DECAY ##1 stateQ == dvcr_pkg::ST_IDLE);
	c_catch: cover property (stateQ == dvcr_pkg::ST_RAMP && catchQ && stopSwitch);
	c_off: cover property (stateQ == dvcr_pkg::ST_OFF && workQ == dvcr_pkg::CODE_OFF
		&& irqStatQ[dvcr_pkg::IRQ_OFF]);
endmodule // dvcr_ramp

/* File: bench/dvcr_rail_model.sv */
`timescale 1ns/1ps
module dvcr_rail_model #(
	parameter int DECAY = 200
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// From the sequencer
	input  wire logic [6:0] workCode,
	input  wire logic       stopSwitch,
	// Comparator levels
	output logic            outBelowHalf,
	output logic            outAboveCode,
	output logic            outBelowOv
);
	// Output level in code units; with switching stopped only the load discharges it
	int vout;
	int cnt;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vout <= 0;
			cnt <= 0;
		end else if (!stopSwitch) begin
			vout <= int'(workCode);
		end else if (cnt == DECAY) begin
			cnt <= 0;
			vout <= (vout > 0) ? vout - 1 : 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	assign outBelowHalf = vout < 4;
	assign outAboveCode = vout > int'(workCode);
	assign outBelowOv = vout <= int'(workCode);
endmodule // dvcr_rail_model

/* File: bench/dvcr_ramp_bench.sv */
`timescale 1ns/1ps
module dvcr_ramp_bench;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        outBelowHalf, outAboveCode, outBelowOv;
	logic [6:0]  workCode, refCode;
	logic        forcePwm, stopSwitch, softStart, railOkMask;
	int          n_fail = 0;
	int          compares = 0;

	dvcr_ramp u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .outBelowHalf(outBelowHalf), .outAboveCode(outAboveCode),
		.outBelowOv(outBelowOv), .workCode(workCode), .refCode(refCode), .forcePwm(forcePwm),
		.stopSwitch(stopSwitch), .softStart(softStart), .railOkMask(railOkMask));
	dvcr_rail_model u_rail (.clk(clk), .nrst(nrst), .workCode(workCode),
		.stopSwitch(stopSwitch), .outBelowHalf(outBelowHalf), .outAboveCode(outAboveCode),
		.outBelowOv(outBelowOv));

	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic tmo();
		chk(1'b0, "wait ran out");
		final_report();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Starts one edge later so a release never meets the next setup in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic err);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) tmo();
		rd = prdata;
		chk(pslverr === err, "bus response");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_code(input logic [6:0] t, input int bound);
		int k;
		k = 0;
		while (workCode !== t && k < bound) begin
			@(posedge clk);
			k++;
		end
		if (workCode !== t) tmo();
	endtask

	task automatic soft_start();
		int k, n;
		k = 0;
		n = 0;
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h06, 1'b0);
		while (workCode !== 7'h06 && k < 5000) begin
			@(posedge clk);
			k++;
			n += int'(softStart);
			chk(forcePwm === 1'b0, "forced mode during soft start");
		end
		if (k == 5000) tmo();
		chk(n >= dvcr_pkg::SOFT_CYC && n <= dvcr_pkg::SOFT_CYC + 2, "soft start length");
	endtask

	task automatic ramp(input logic [6:0] t, input logic fine, input int step);
		int k, last;
		logic [6:0] prev;
		apb(1'b1, dvcr_pkg::OFF_CTRL, {23'h0, fine, 1'b0, t}, 1'b0);
		k = 0;
		last = -1;
		prev = workCode;
		while (workCode !== t && k < 4000) begin
			@(posedge clk);
			k++;
			if (workCode !== prev) begin
				if (last >= 0) chk(k - last == step, "step interval");
				chk(workCode - prev == 1 || prev - workCode == 1, "code jump");
				if (workCode !== t) chk(forcePwm === 1'b1 && railOkMask === 1'b1, "ramp");
				last = k;
				prev = workCode;
			end
		end
		if (k == 4000) tmo();
		cyc(3);
		chk(forcePwm === 1'b0 && railOkMask === 1'b0, "ramp end");
		chk(refCode === t, "converter reference");
	endtask

	task automatic raise_in_decay();
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h88, 1'b0);
		cyc(4);
		chk(workCode === 7'h08 && stopSwitch === 1'b1, "decay entry");
		chk(forcePwm === 1'b0 && railOkMask === 1'b1, "decay mode");
		cyc(300);
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h10, 1'b0);
		wait_code(7'h09, 400);
		chk(stopSwitch === 1'b1, "switching held above code");
		wait_code(7'h10, 2000);
		cyc(3);
		chk(stopSwitch === 1'b0 && railOkMask === 1'b0, "ramp after decay");
	endtask

	task automatic decay_mask();
		int k;
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h8a, 1'b0);
		cyc(4);
		chk(railOkMask === 1'b1, "mask in decay");
		k = 0;
		while (railOkMask === 1'b1 && k < 4000) begin
			@(posedge clk);
			k++;
		end
		if (k == 4000) tmo();
		chk(u_rail.vout <= 10, "mask released above level");
	endtask

	task automatic controller_mode();
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h60b, 1'b0);
		wait_code(7'h0b, 1000);
		cyc(3);
		chk(forcePwm === 1'b1, "software forced mode");
		chk(refCode === dvcr_pkg::CTL_FLOOR, "controller floor");
	endtask

	task automatic to_zero();
		int k;
		logic [6:0] prev;
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h00, 1'b0);
		k = 0;
		prev = workCode;
		while (workCode !== 7'h00 && k < 3000) begin
			@(posedge clk);
			k++;
			if (workCode !== 7'h00) prev = workCode;
		end
		if (k == 3000) tmo();
		chk(prev === dvcr_pkg::HALF_25MV, "lowest code before off");
		cyc(3);
		chk(stopSwitch === 1'b1, "switching stopped");
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h01, 1'b0);
		cyc(20);
		chk(workCode === 7'h00, "code one from off");
	endtask

	task automatic regs_irq();
		apb(1'b0, dvcr_pkg::OFF_STAT, 32'h0, 1'b0);
		chk(rd === 32'h400, "status when off");
		apb(1'b0, 8'h10, 32'h0, 1'b1);
		chk(rd === 32'h0, "unmapped read");
		apb(1'b0, dvcr_pkg::OFF_IRQ, 32'h0, 1'b0);
		chk(rd === 32'hf, "events seen");
		chk(irq === 1'b0, "irq masked");
		apb(1'b1, dvcr_pkg::OFF_MASK, 32'h8, 1'b0);
		cyc(3);
		chk(irq === 1'b1, "irq unmasked");
		apb(1'b1, dvcr_pkg::OFF_IRQ, 32'h8, 1'b0);
		cyc(3);
		chk(irq === 1'b0, "irq cleared");
		apb(1'b0, dvcr_pkg::OFF_IRQ, 32'h0, 1'b0);
		chk(rd === 32'h7, "one event cleared");
	endtask

	initial begin
		cyc(100000);
		tmo();
	end

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cyc(8);
		chk(workCode === 7'h00 && stopSwitch === 1'b1 && railOkMask === 1'b0, "reset state");
		nrst <= 1'b1;
		soft_start();
		ramp(7'h09, 1'b0, 120);
		ramp(7'h0c, 1'b1, 60);
		apb(1'b1, dvcr_pkg::OFF_CTRL, 32'h10, 1'b0);
		cyc(150);
		ramp(7'h0e, 1'b0, 120);
		raise_in_decay();
		decay_mask();
		controller_mode();
		to_zero();
		regs_irq();
		final_report();
	end
endmodule // dvcr_ramp_bench
